// ===== pkg/eid_pkg.sv
// Package: register map, field layout and types for the encoder decoder
package eid_pkg;
   // Register byte offsets (one 32-bit word each)
   localparam logic [5:0] EID_AXIS0_CFG  = 6'h00;
   localparam logic [5:0] EID_AXIS1_CFG  = 6'h04;
   localparam logic [5:0] EID_AXIS2_CFG  = 6'h08;
   localparam logic [5:0] EID_IRQ_SEL    = 6'h24;
   localparam logic [5:0] EID_IRQ_STAT   = 6'h30;
   localparam logic [5:0] EID_IRQ_MASK   = 6'h34;
   localparam logic [5:0] EID_CNT0       = 6'h10;
   localparam logic [5:0] EID_CNT1       = 6'h14;
   localparam logic [5:0] EID_CNT2       = 6'h18;
   localparam logic [5:0] EID_INPUTS     = 6'h1C;
   // Axis config fields
   localparam int EID_MODE_LSB   = 0;
   localparam int EID_RES_LSB    = 4;
   localparam int EID_RVS_BIT    = 3;
   localparam int EID_IDXCLR_BIT = 6;
   // Interrupt select field
   localparam int EID_SEL7_BIT   = 3;
   localparam int EID_NSRC       = 8;
   localparam int EID_NAXIS      = 3;
   localparam int EID_CW         = 24;
   localparam logic [7:0] EID_IRQ_RST  = 8'h00;
   localparam logic [7:0] EID_CFG_RST  = 8'h00;
   // Filter needs three equal samples
   localparam int EID_FILT_LEN   = 3;
   typedef enum logic [1:0] {
      EID_MODE_OFF  = 2'h0,
      EID_MODE_QUAD = 2'h1,
      EID_MODE_TWO  = 2'h2,
      EID_MODE_ONE  = 2'h3
   } eid_mode_t;
   typedef enum logic [1:0] {
      EID_RES_X1 = 2'h0,
      EID_RES_X2 = 2'h1,
      EID_RES_X4 = 2'h2
   } eid_res_t;
   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } eid_axis_in_t;
   typedef struct packed {
      logic up;
      logic dn;
   } eid_step_t;
endpackage : eid_pkg

// ===== logic/eid_filter.sv
// Synchroniser plus three-sample glitch filter for one input
`timescale 1ns/10ps
`default_nettype none
module eid_filter
   import eid_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Sample enable and pin
   input  wire logic smp_en_i,
   input  wire logic pin_i,
   // Filtered level
   output logic      lvl_o
);
   logic       s1_q, s2_q, s1_d, s2_d;
   logic [EID_FILT_LEN-1:0] sh_q, sh_d;
   logic       lvl_q, lvl_d;

   always_comb begin
      s1_d  = pin_i;
      s2_d  = s1_q;
      sh_d  = sh_q;
      lvl_d = lvl_q;
      if (smp_en_i) begin
         sh_d = {sh_q[EID_FILT_LEN-2:0], s2_q};
      end
      if (&sh_q) begin
         lvl_d = 1'b1;
      end else if (~|sh_q) begin
         lvl_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         sh_q  <= '0;
         lvl_q <= 1'b0;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end
   assign lvl_o = lvl_q;
endmodule : eid_filter
`default_nettype wire

// ===== logic/eid_top.sv
// Three-axis encoder input decoder with Wishbone registers
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module eid_top
   import eid_pkg::*;
#(
   parameter int SMP_DIV = 6
)(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [5:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Encoder and general inputs
   input  wire eid_axis_in_t [EID_NAXIS-1:0] axis_i,
   input  wire logic              general_input_zero_i,
   input  wire logic              general_input_one_i,
   input  wire logic              timer_pulse_i,
   // Interrupt
   output logic [EID_NSRC-1:0]    irq_src_o,
   output logic                   irq_o
);
   ////////////////////////////////////////////////////////////////////
   // Sample divider
   logic [7:0] div_q, div_d;
   logic       smp_en;
   always_comb begin
      smp_en = (div_q == 8'(SMP_DIV - 1));
      div_d  = smp_en ? 8'h00 : div_q + 8'h01;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) div_q <= 8'h00;
      else       div_q <= div_d;
   end

   ////////////////////////////////////////////////////////////////////
   // Input filters
   eid_axis_in_t [EID_NAXIS-1:0] flt;
   logic gi0_f, gi1_f, tmr_f;
   for (genvar g = 0; g < EID_NAXIS; g++) begin : g_flt
      eid_filter u_fa (.clk_i(clk_i), .rst_i(rst_i), .smp_en_i(smp_en),
                       .pin_i(axis_i[g].a), .lvl_o(flt[g].a));
      eid_filter u_fb (.clk_i(clk_i), .rst_i(rst_i), .smp_en_i(smp_en),
                       .pin_i(axis_i[g].b), .lvl_o(flt[g].b));
      eid_filter u_fz (.clk_i(clk_i), .rst_i(rst_i), .smp_en_i(smp_en),
                       .pin_i(axis_i[g].z), .lvl_o(flt[g].z));
   end
   eid_filter u_f0 (.clk_i(clk_i), .rst_i(rst_i), .smp_en_i(smp_en),
                    .pin_i(general_input_zero_i), .lvl_o(gi0_f));
   eid_filter u_f1 (.clk_i(clk_i), .rst_i(rst_i), .smp_en_i(smp_en),
                    .pin_i(general_input_one_i), .lvl_o(gi1_f));
   // Timer is same-clock logic: no synchroniser or glitch filter, fed straight to its edge detector
   assign tmr_f = timer_pulse_i;

   ////////////////////////////////////////////////////////////////////
   // Registers and decoder state
   logic [7:0]          cfg_q [EID_NAXIS];
   logic [7:0]          cfg_d [EID_NAXIS];
   logic [7:0]          isel_q, isel_d, mask_q, mask_d, stat_q, stat_d;
   logic [EID_CW-1:0]   cnt_q [EID_NAXIS];
   logic [EID_CW-1:0]   cnt_d [EID_NAXIS];
   eid_axis_in_t [EID_NAXIS-1:0] prv_q;
   logic                gi0_p_q, gi1_p_q, tmr_p_q;
   logic                ack_q, ack_d;
   logic [31:0]         rd_q, rd_d;
   logic [EID_NSRC-1:0] src_q, src_d;
   eid_step_t           stp [EID_NAXIS];
   logic [EID_NAXIS-1:0] ovf, idx_rise;

   function automatic logic [EID_CW-1:0] init_val(input logic rvs);
      init_val = rvs ? {1'b1, {(EID_CW-1){1'b0}}} : '0;
   endfunction : init_val

   // Step decode for one axis
   function automatic eid_step_t decode(input logic [7:0] cfg,
                                       input eid_axis_in_t cur,
                                       input eid_axis_in_t prv);
      eid_step_t s;
      logic ea, eb, ra, dir;
      s   = '0;
      ea  = cur.a ^ prv.a;
      eb  = cur.b ^ prv.b;
      ra  = cur.a & ~prv.a;
      dir = ea ? (cur.a ^ cur.b) : ~(cur.a ^ cur.b);
      case (eid_mode_t'(cfg[EID_MODE_LSB +: 2]))
         EID_MODE_QUAD: begin
            case (eid_res_t'(cfg[EID_RES_LSB +: 2]))
               EID_RES_X1: if (ra) begin
                  s.up = ~cur.b;
                  s.dn = cur.b;
               end
               EID_RES_X2: if (ea) begin
                  s.up = dir;
                  s.dn = ~dir;
               end
               default: if (ea | eb) begin
                  s.up = dir;
                  s.dn = ~dir;
               end
            endcase
         end
         // A up, B down; both cancel
         EID_MODE_TWO: begin
            s.up = ra & ~(cur.b & ~prv.b);
            s.dn = (cur.b & ~prv.b) & ~ra;
         end
         EID_MODE_ONE: begin
            s.up = ra & cur.b;
            s.dn = ra & ~cur.b;
         end
         default: s = '0;
      endcase
      decode = s;
   endfunction : decode

   ////////////////////////////////////////////////////////////////////
   // Counting, interrupts and bus
   logic acc, wr, rd;
   always_comb begin
      acc = cyc_i & stb_i & ~ack_q;
      wr  = acc & we_i & sel_i[0];
      rd  = acc & ~we_i;
      ack_d  = acc;
      isel_d = isel_q;
      mask_d = mask_q;
      rd_d   = 32'h0000_0000;
      for (int i = 0; i < EID_NAXIS; i++) begin
         cfg_d[i]    = cfg_q[i];
         // one event per axis per clock
         stp[i]      = decode(cfg_q[i], flt[i], prv_q[i]);
         idx_rise[i] = flt[i].z & ~prv_q[i].z;
         ovf[i]      = (stp[i].up & (&cnt_q[i])) |
                       (stp[i].dn & ~|cnt_q[i]);
         cnt_d[i]    = cnt_q[i];
         if (stp[i].up) cnt_d[i] = cnt_q[i] + EID_CW'(1);
         else if (stp[i].dn) cnt_d[i] = cnt_q[i] - EID_CW'(1);
         if (idx_rise[i] & cfg_q[i][EID_IDXCLR_BIT])
            cnt_d[i] = init_val(cfg_q[i][EID_RVS_BIT]);
      end
      src_d[2:0] = ovf;
      src_d[5:3] = idx_rise;
      src_d[6]   = gi0_f & ~gi0_p_q;
      src_d[7]   = isel_q[EID_SEL7_BIT] ? (tmr_f & ~tmr_p_q)
                                        : (gi1_f & ~gi1_p_q);
      stat_d = stat_q;
      if (rd && adr_i == EID_IRQ_STAT) stat_d = 8'h00;
      // Set wins over read-clear
      stat_d = stat_d | src_d;
      if (wr) begin
         if (adr_i == EID_AXIS0_CFG) begin
            cfg_d[0] = dat_i[7:0];
         end else if (adr_i == EID_AXIS1_CFG) begin
            cfg_d[1] = dat_i[7:0];
         end else if (adr_i == EID_AXIS2_CFG) begin
            cfg_d[2] = dat_i[7:0];
         end else if (adr_i == EID_IRQ_SEL) begin
            isel_d = dat_i[7:0];
         end else if (adr_i == EID_IRQ_MASK) begin
            mask_d = dat_i[7:0];
         end
      end
      // Changing a config word reloads that counter's initial value
      for (int i = 0; i < EID_NAXIS; i++) begin
         if (cfg_d[i] != cfg_q[i])
            cnt_d[i] = init_val(cfg_d[i][EID_RVS_BIT]);
      end
      if (rd) begin
         if (adr_i == EID_AXIS0_CFG) begin
            rd_d = {24'h000000, cfg_q[0]};
         end else if (adr_i == EID_AXIS1_CFG) begin
            rd_d = {24'h000000, cfg_q[1]};
         end else if (adr_i == EID_AXIS2_CFG) begin
            rd_d = {24'h000000, cfg_q[2]};
         end else if (adr_i == EID_CNT0) begin
            rd_d = {8'h00, cnt_q[0]};
         end else if (adr_i == EID_CNT1) begin
            rd_d = {8'h00, cnt_q[1]};
         end else if (adr_i == EID_CNT2) begin
            rd_d = {8'h00, cnt_q[2]};
         end else if (adr_i == EID_INPUTS) begin
            rd_d = {21'h000000, gi1_f, gi0_f, flt};
         end else if (adr_i == EID_IRQ_SEL) begin
            rd_d = {24'h000000, isel_q};
         end else if (adr_i == EID_IRQ_STAT) begin
            rd_d = {24'h000000, stat_q};
         end else if (adr_i == EID_IRQ_MASK) begin
            rd_d = {24'h000000, mask_q};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < EID_NAXIS; i++) begin
            cfg_q[i] <= EID_CFG_RST;
            cnt_q[i] <= '0;
         end
         prv_q   <= '0;
         gi0_p_q <= 1'b0;
         gi1_p_q <= 1'b0;
         tmr_p_q <= 1'b0;
         isel_q  <= EID_IRQ_RST;
         mask_q  <= EID_IRQ_RST;
         stat_q  <= EID_IRQ_RST;
         src_q   <= '0;
         ack_q   <= 1'b0;
         rd_q    <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < EID_NAXIS; i++) begin
            cfg_q[i] <= cfg_d[i];
            cnt_q[i] <= cnt_d[i];
         end
         prv_q   <= flt;
         gi0_p_q <= gi0_f;
         gi1_p_q <= gi1_f;
         tmr_p_q <= tmr_f;
         isel_q  <= isel_d;
         mask_q  <= mask_d;
         stat_q  <= stat_d;
         src_q   <= src_d;
         ack_q   <= ack_d;
         rd_q    <= rd_d;
      end
   end

   assign irq_src_o = src_q;
   assign irq_o     = |(stat_q & mask_q);
   assign ack_o     = ack_q;
   assign dat_o     = rd_q;
endmodule : eid_top
`default_nettype wire

// ===== dv/eid_asserts.sv
// Port checks for the encoder decoder, bound to its top
`timescale 1ns/10ps
`default_nettype none
module eid_asserts
   import eid_pkg::*;
#(
   parameter int SMP_DIV = 6
)(
   // Clock, reset and bus
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic                we_i,
   input wire logic                ack_o,
   // Inputs and interrupts
   input wire logic                general_input_zero_i,
   input wire logic [EID_NSRC-1:0] irq_src_o,
   input wire logic                irq_o
);
   // Shortest high run that the filter may pass
   localparam int MIN_RUN = 2 * SMP_DIV + 1;
   logic [7:0] run_q;
   logic [7:0] last_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q  <= 8'h00;
         last_q <= 8'h00;
      end else begin
         run_q <= general_input_zero_i ?
                  run_q + {7'h00, run_q != 8'hFF} : 8'h00;
         if (!general_input_zero_i && run_q != 8'h00)
            last_q <= run_q;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o
      && irq_src_o == 8'h00) else $error("outputs active after reset");
   src_pulse_a: assert property (
      (irq_src_o & $past(irq_src_o)) == 8'h00)
      else $error("source event longer than one cycle");
   filter_len_a: assert property (
      irq_src_o[6] |-> run_q >= MIN_RUN || last_q >= MIN_RUN)
      else $error("short input pulse passed the filter");
   irq_rise_a: assert property ($rose(irq_o) |->
      (|irq_src_o) || $past(|irq_src_o) || ack_o || $past(ack_o))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property (
      $fell(irq_o) |-> ack_o || $past(ack_o))
      else $error("interrupt fell without access");
   cover property (irq_src_o[6]);
   cover property (irq_src_o[7]);
   cover property (ack_o && we_i && irq_o);
endmodule : eid_asserts
bind eid_top eid_asserts #(.SMP_DIV(SMP_DIV)) eid_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .ack_o(ack_o), .irq_src_o(irq_src_o), .irq_o(irq_o),
   .general_input_zero_i(general_input_zero_i));
`default_nettype wire

// ===== dv/eid_enc_model.sv
// Encoders and general digital inputs facing the decoder
`timescale 1ns/10ps
`default_nettype none
module eid_enc_model
   import eid_pkg::*;
#(
   parameter int HOLD = 12
)(
   // Clock
   input  wire logic                     clk_i,
   // Pins toward the decoder
   output eid_axis_in_t [EID_NAXIS-1:0] axis_o,
   output logic                         gi0_o,
   output logic                         gi1_o
);
   initial begin
      axis_o = '0;
      gi0_o  = 1'b0;
      gi1_o  = 1'b0;
   end
   task automatic pins(input int ax, input logic [2:0] abz);
      @(posedge clk_i);
      axis_o[ax] <= abz;
      repeat (HOLD) @(posedge clk_i);
   endtask : pins
   task automatic gin(input logic g0, input logic g1, input int n);
      @(posedge clk_i);
      gi0_o <= g0;
      gi1_o <= g1;
      repeat (n) @(posedge clk_i);
   endtask : gin
   task automatic turn(input int ax, input bit fwd);
      pins(ax, fwd ? 3'b100 : 3'b010);
      pins(ax, 3'b110);
      pins(ax, fwd ? 3'b010 : 3'b100);
      pins(ax, 3'b000);
   endtask : turn
endmodule : eid_enc_model
`default_nettype wire

// ===== dv/encoder_input_decode_bench.sv
// Self-checking bench for the encoder decoder
`timescale 1ns/10ps
`default_nettype none
module encoder_input_decode_bench
   import eid_pkg::*;
;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, timer_i, irq_o, gi0, gi1;
   logic [5:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [EID_NSRC-1:0] irq_src_o;
   eid_axis_in_t [EID_NAXIS-1:0] axis;
   int miscompares, check_count;
   int src7_seen;
   eid_top #(.SMP_DIV(1)) eid_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .axis_i(axis), .general_input_zero_i(gi0),
      .general_input_one_i(gi1), .timer_pulse_i(timer_i),
      .irq_src_o(irq_src_o), .irq_o(irq_o));
   eid_enc_model eid_enc_model_inst (.clk_i(clk_i), .axis_o(axis),
      .gi0_o(gi0), .gi1_o(gi1));
   // Source-7 pulses, counted for the select checks
   always @(posedge clk_i) begin
      if (irq_src_o[7] === 1'b1) src7_seen <= src7_seen + 1;
   end
   task summarize;
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Classic cycle, held until ack is sampled
   task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         summarize();
      end
   endtask : wb
   task rd(input string nm, input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd
   task tpulse;
      @(posedge clk_i);
      timer_i <= 1'b1;
      @(posedge clk_i);
      timer_i <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask : tpulse
   task t_reset;
      rd("cfg0", EID_AXIS0_CFG, 32'h0);
      rd("mask", EID_IRQ_MASK, 32'h0);
      rd("sel", EID_IRQ_SEL, 32'h0);
      wb(1'b1, 6'h3C, 32'hFF);
      rd("unmapped", 6'h3C, 32'h0);
      eid_enc_model_inst.pins(0, 3'b100);
      eid_enc_model_inst.pins(0, 3'b000);
      rd("off", EID_CNT0, 32'h0);
   endtask : t_reset
   task t_two;
      wb(1'b1, EID_AXIS0_CFG, 32'h0A);
      repeat (3) begin
         eid_enc_model_inst.pins(0, 3'b100);
         eid_enc_model_inst.pins(0, 3'b000);
      end
      eid_enc_model_inst.pins(0, 3'b010);
      eid_enc_model_inst.pins(0, 3'b000);
      rd("two", EID_CNT0, 32'h00800002);
   endtask : t_two
   task t_one;
      wb(1'b1, EID_AXIS1_CFG, 32'h03);
      eid_enc_model_inst.pins(1, 3'b010);
      repeat (2) begin
         eid_enc_model_inst.pins(1, 3'b110);
         eid_enc_model_inst.pins(1, 3'b010);
      end
      eid_enc_model_inst.pins(1, 3'b000);
      eid_enc_model_inst.pins(1, 3'b100);
      eid_enc_model_inst.pins(1, 3'b000);
      rd("one", EID_CNT1, 32'h1);
   endtask : t_one
   task t_quad;
      for (int r = 0; r < 3; r++) begin
         wb(1'b1, EID_AXIS2_CFG, 32'h01 | (r << EID_RES_LSB));
         eid_enc_model_inst.turn(2, 1'b1);
         rd("res", EID_CNT2, 32'h1 << r);
      end
   endtask : t_quad
   task t_wrap_index;
      wb(1'b0, EID_IRQ_STAT, 32'h0);
      wb(1'b1, EID_AXIS2_CFG, 32'h61);
      eid_enc_model_inst.turn(2, 1'b0);
      rd("down", EID_CNT2, 32'h00FFFFFC);
      rd("wrap", EID_IRQ_STAT, 32'h04);
      eid_enc_model_inst.turn(2, 1'b1);
      eid_enc_model_inst.turn(2, 1'b1);
      eid_enc_model_inst.pins(2, 3'b001);
      eid_enc_model_inst.pins(2, 3'b000);
      rd("index", EID_CNT2, 32'h0);
      rd("idxstat", EID_IRQ_STAT, 32'h24);
   endtask : t_wrap_index
   task t_irq;
      wb(1'b1, EID_IRQ_MASK, 32'h40);
      eid_enc_model_inst.gin(1'b1, 1'b0, 1);
      eid_enc_model_inst.gin(1'b0, 1'b0, 12);
      chk("glitch", 32'h0, {31'h0, irq_o});
      eid_enc_model_inst.gin(1'b1, 1'b0, 12);
      rd("inputs", EID_INPUTS, 32'h200);
      eid_enc_model_inst.gin(1'b0, 1'b0, 12);
      chk("irq", 32'h1, {31'h0, irq_o});
      rd("in0", EID_IRQ_STAT, 32'h40);
      chk("cleared", 32'h0, {31'h0, irq_o});
      wb(1'b1, EID_IRQ_MASK, 32'h00);
      eid_enc_model_inst.gin(1'b1, 1'b0, 12);
      eid_enc_model_inst.gin(1'b0, 1'b0, 12);
      chk("masked", 32'h0, {31'h0, irq_o});
      rd("sticky", EID_IRQ_STAT, 32'h40);
   endtask : t_irq
   task t_sel;
      wb(1'b1, EID_IRQ_SEL, 32'h08);
      tpulse();
      rd("timer", EID_IRQ_STAT, 32'h80);
      eid_enc_model_inst.gin(1'b0, 1'b1, 12);
      eid_enc_model_inst.gin(1'b0, 1'b0, 12);
      rd("in1off", EID_IRQ_STAT, 32'h00);
      wb(1'b1, EID_IRQ_SEL, 32'h00);
      eid_enc_model_inst.gin(1'b0, 1'b1, 12);
      eid_enc_model_inst.gin(1'b0, 1'b0, 12);
      rd("in1", EID_IRQ_STAT, 32'h80);
      tpulse();
      rd("timeroff", EID_IRQ_STAT, 32'h00);
      chk("src7", 32'h2, src7_seen);
   endtask : t_sel
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      {cyc_i, stb_i, we_i, timer_i} = 4'h0;
      sel_i = 4'h0;
      adr_i = 6'h00;
      dat_i = 32'h0;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_two();
      t_one();
      t_quad();
      t_wrap_index();
      t_irq();
      t_sel();
      summarize();
   end
endmodule : encoder_input_decode_bench
`default_nettype wire
